//--- hw/scfg_top.sv
// module: serial/parallel configuration, lock qualification and output control
`default_nettype none
module scfg_top
  import scfg_pkg::*;
#(
  parameter int LOCK_QUAL_CYCLES = LOCK_QUAL_DEFAULT
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       address_select_hi,
  input  wire logic       address_select_lo,
  input  wire logic       master_reset_n,
  input  wire logic       parallel_select_n,
  input  wire logic [9:0] feedback_pins,
  input  wire logic [2:0] primary_post_divider_pins,
  input  wire logic       secondary_post_divider_pin,
  input  wire logic       pre_divider_pin,
  input  wire logic       pll_freq_lock,
  input  wire logic [1:0] output_stop_n,
  output logic            lock_out,
  output logic [9:0]      feedback_divider,
  output logic            pre_divider_sel,
  output logic [2:0]      primary_post_divider,
  output logic            secondary_post_divider,
  output logic            primary_clock_out,
  output logic            secondary_clock_out
);
  // ----------------------------------------------------------------
  // input synchronizers
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  logic [NSYNC-1:0] s3;
  logic [NSYNC-1:0] filt;

  assign pins_raw = {pre_divider_pin, secondary_post_divider_pin, primary_post_divider_pins,
                     feedback_pins, address_select_hi, address_select_lo, output_stop_n,
                     pll_freq_lock, parallel_select_n, master_reset_n, sda_in, scl_in};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          s1[g] <= SYNC_RESET[g];
          s2[g] <= SYNC_RESET[g];
          s3[g] <= SYNC_RESET[g];
          filt[g] <= SYNC_RESET[g];
        end else begin
          s1[g] <= pins_raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            filt[g] <= s3[g];
          end
        end
      end
    end
  endgenerate

  logic       scl;
  logic       sda;
  logic       mr_n;
  logic       psel_n;
  logic [9:0] pin_m;
  logic [2:0] pin_na;
  logic       scl_d;
  logic       sda_d;
  logic       mr_d;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       mr_rise;

  assign scl = filt[SY_SCL];
  assign sda = filt[SY_SDA];
  assign mr_n = filt[SY_MR];
  assign psel_n = filt[SY_PSEL];
  assign pin_m = filt[SY_M +: 10];
  assign pin_na = filt[SY_NA +: 3];
  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign bus_start = scl & scl_d & sda_d & ~sda;
  assign bus_stop = scl & scl_d & ~sda_d & sda;
  assign mr_rise = mr_n & ~mr_d;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      mr_d <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      mr_d <= mr_n;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers and active dividers
  // ----------------------------------------------------------------
  logic [7:0] reg_l;
  logic [7:1] reg_h;
  logic [9:0] act_m;
  logic [2:0] act_na;
  logic       act_nb;
  logic       act_p;
  logic [7:0] next_reg_l;
  logic [7:1] next_reg_h;
  logic [9:0] next_act_m;
  logic [2:0] next_act_na;
  logic       next_act_nb;
  logic       next_act_p;
  logic       wr_en;
  logic [7:0] wr_ptr;
  logic [7:0] wr_data;
  logic       lock;

  always_comb begin
    next_reg_l = reg_l;
    next_reg_h = reg_h;
    next_act_m = act_m;
    next_act_na = act_na;
    next_act_nb = act_nb;
    next_act_p = act_p;
    if (mr_rise || !psel_n) begin
      // capture ignores the programming mode
      next_act_m = pin_m;
      next_act_na = pin_na;
      next_act_nb = filt[SY_NB];
      next_act_p = filt[SY_P];
      next_reg_l = pin_m[7:0];
      next_reg_h = {pin_m[9:8], pin_na, filt[SY_NB], filt[SY_P]};
    end else if (wr_en) begin
      if (wr_ptr == REG_L_OFFSET) begin
        next_reg_l = wr_data;
      end else if (wr_ptr == REG_H_OFFSET) begin
        next_reg_h = wr_data[7:1];
      end else if (wr_ptr == REG_CMD_OFFSET) begin
        case (wr_data[3:0])
          CMD_STEP_UP: next_act_m = 10'(act_m + 10'h001);
          CMD_STEP_DOWN: next_act_m = 10'(act_m - 10'h001);
          CMD_APPLY: begin
            next_act_m = {reg_h[7:6], reg_l};
            next_act_na = reg_h[H_NA +: 3];
            next_act_nb = reg_h[H_NB];
            next_act_p = reg_h[H_P];
          end
          CMD_READBACK: begin
            next_reg_l = act_m[7:0];
            next_reg_h = {act_m[9:8], act_na, act_nb, act_p};
          end
          default: next_act_m = act_m;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_l <= DEF_M[7:0];
      reg_h <= {DEF_M[9:8], DEF_NA, DEF_NB, DEF_P};
      act_m <= DEF_M;
      act_na <= DEF_NA;
      act_nb <= DEF_NB;
      act_p <= DEF_P;
    end else begin
      reg_l <= next_reg_l;
      reg_h <= next_reg_h;
      act_m <= next_act_m;
      act_na <= next_act_na;
      act_nb <= next_act_nb;
      act_p <= next_act_p;
    end
  end

  // pll uses: vco = ref * m / p, output = vco / post divider
  assign feedback_divider = act_m;
  assign pre_divider_sel = act_p;
  assign primary_post_divider = act_na;
  assign secondary_post_divider = act_nb;

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  scfg_state_type st;
  scfg_state_type next_st;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [2:0] bitcnt;
  logic [2:0] next_bitcnt;
  logic       drive;
  logic       next_drive;
  logic       is_rd;
  logic       next_is_rd;
  logic       is_data;
  logic       next_is_data;
  logic       byte_sel;
  logic       next_byte_sel;
  logic       ack_ok;
  logic       next_ack_ok;
  logic       next_wr_en;
  logic [7:0] next_wr_ptr;
  logic [7:0] next_wr_data;
  logic [7:0] rd_hi;

  // only the two configuration registers are ever sent
  assign rd_hi = {reg_h, lock};

  always_comb begin
    next_st = st;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_drive = drive;
    next_is_rd = is_rd;
    next_is_data = is_data;
    next_byte_sel = byte_sel;
    next_ack_ok = ack_ok;
    next_wr_en = 1'b0;
    next_wr_ptr = wr_ptr;
    next_wr_data = wr_data;
    if (!mr_n || bus_stop) begin
      next_st = SCFG_IDLE;
      next_drive = 1'b0;
    end else if (bus_start) begin
      next_st = SCFG_ADDR;
      next_bitcnt = 3'h0;
      next_drive = 1'b0;
    end else begin
      case (st)
        SCFG_ADDR, SCFG_RX: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda};
            next_bitcnt = 3'(bitcnt + 3'h1);
            if (bitcnt == 3'h7) begin
              next_st = (st == SCFG_ADDR) ? SCFG_ADDR_ACK : SCFG_RX_END;
            end
          end
        end
        SCFG_ADDR_ACK: begin
          if (scl_fall) begin
            if (shreg[7:1] == {ADDR_FIXED, filt[SY_ADR + 1], filt[SY_ADR]}) begin
              next_drive = 1'b1;
              next_is_rd = shreg[0];
              next_st = SCFG_ACK_HOLD;
            end else begin
              next_st = SCFG_IDLE;
            end
          end
        end
        SCFG_ACK_HOLD: begin
          if (scl_fall) begin
            next_bitcnt = 3'h0;
            if (is_rd) begin
              // data follows the address directly, low register first
              next_shreg = reg_l;
              next_drive = ~reg_l[7];
              next_byte_sel = 1'b0;
              next_st = SCFG_TX;
            end else begin
              next_drive = 1'b0;
              next_is_data = 1'b0;
              next_st = SCFG_RX;
            end
          end
        end
        SCFG_TX: begin
          if (scl_fall) begin
            next_shreg = {shreg[6:0], 1'b0};
            next_drive = ~shreg[6];
          end else if (scl_rise) begin
            next_bitcnt = 3'(bitcnt + 3'h1);
            if (bitcnt == 3'h7) begin
              next_st = SCFG_TX_END;
            end
          end
        end
        SCFG_TX_END: begin
          if (scl_fall) begin
            next_drive = 1'b0;
            next_st = SCFG_MACK;
          end
        end
        SCFG_MACK: begin
          if (scl_rise) begin
            next_ack_ok = ~sda;
          end else if (scl_fall) begin
            if (ack_ok) begin
              next_byte_sel = ~byte_sel;
              next_shreg = byte_sel ? reg_l : rd_hi;
              next_drive = byte_sel ? ~reg_l[7] : ~rd_hi[7];
              next_bitcnt = 3'h0;
              next_st = SCFG_TX;
            end else begin
              next_st = SCFG_IDLE;
            end
          end
        end
        SCFG_RX_END: begin
          if (scl_fall) begin
            next_drive = 1'b1;
            next_st = SCFG_RX_ACK;
          end
        end
        SCFG_RX_ACK: begin
          if (scl_fall) begin
            next_drive = 1'b0;
            next_bitcnt = 3'h0;
            next_is_data = ~is_data;
            if (is_data) begin
              next_wr_data = shreg;
              next_wr_en = 1'b1;
            end else begin
              next_wr_ptr = shreg;
            end
            next_st = SCFG_RX;
          end
        end
        default: next_st = SCFG_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= SCFG_IDLE;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      drive <= 1'b0;
      is_rd <= 1'b0;
      is_data <= 1'b0;
      byte_sel <= 1'b0;
      ack_ok <= 1'b0;
      wr_en <= 1'b0;
      wr_ptr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      st <= next_st;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      drive <= next_drive;
      is_rd <= next_is_rd;
      is_data <= next_is_data;
      byte_sel <= next_byte_sel;
      ack_ok <= next_ack_ok;
      wr_en <= next_wr_en;
      wr_ptr <= next_wr_ptr;
      wr_data <= next_wr_data;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive;

  // ----------------------------------------------------------------
  // lock qualification
  // ----------------------------------------------------------------
  logic [31:0] lock_cnt;
  logic [31:0] next_lock_cnt;
  logic        next_lock;

  always_comb begin
    next_lock_cnt = lock_cnt;
    next_lock = lock;
    if (!filt[SY_LOCK]) begin
      next_lock_cnt = 32'h00000000;
      next_lock = 1'b0;
    end else if (lock_cnt >= 32'(LOCK_QUAL_CYCLES)) begin
      next_lock = 1'b1;
    end else begin
      next_lock_cnt = 32'(lock_cnt + 32'h00000001);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock_cnt <= 32'h00000000;
      lock <= 1'b0;
    end else begin
      lock_cnt <= next_lock_cnt;
      lock <= next_lock;
    end
  end

  // pin and register bit share one flop
  assign lock_out = lock;

  // ----------------------------------------------------------------
  // output clocks
  // ----------------------------------------------------------------
  scfg_clk_if cif ();

  assign cif.na = act_na;
  assign cif.nb = act_nb;
  assign cif.run = mr_n;
  assign cif.stop_n = filt[SY_STOP +: 2];

  scfg_outgate u_gate (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .cif     (cif)
  );

  assign primary_clock_out = cif.clk_out[0];
  assign secondary_clock_out = cif.clk_out[1];
endmodule
`default_nettype wire

//--- hw/scfg_pkg.sv
// package: constants, states and layouts of the synthesizer configuration block
// Overview of operation
// - read returns low then high register
// - read starts at address, no pointer
// - command register never appears on reads
// - address 10110 plus two pins, read bit
// - registers and active dividers may differ
// - readback command copies active into registers
// - capture pins at master reset release
// - capture same in either programming mode
// - floating pins give default M 500, NA 010, NB 0, P 0
// - parallel mode: dividers follow pins continuously
// - parallel configuration readable over serial
// - lock pin and bit change together
// - lock drops immediately on lost lock
// - lock reported after qualifying delay
// - relock retried and reported after loss
// - stop input holds output low
// - stop synchronized, no runt pulses
// - independent stops, half-rate alignment may differ
// - coincident rising edges stay coincident
// - master reset forces outputs low
// - apply command copies registers into dividers
// - readback opcode 0x08, upper nibble ignored
// - step up/down changes feedback only
`default_nettype none
package scfg_pkg;
  localparam logic [4:0] ADDR_FIXED     = 5'h16;
  localparam logic [7:0] REG_L_OFFSET   = 8'h00;
  localparam logic [7:0] REG_H_OFFSET   = 8'h01;
  localparam logic [7:0] REG_CMD_OFFSET = 8'hF0;
  localparam logic [3:0] CMD_STEP_UP    = 4'h1;
  localparam logic [3:0] CMD_STEP_DOWN  = 4'h2;
  localparam logic [3:0] CMD_APPLY      = 4'h4;
  localparam logic [3:0] CMD_READBACK   = 4'h8;
  // high register field positions
  localparam int H_M_HI  = 6;
  localparam int H_NA    = 3;
  localparam int H_NB    = 2;
  localparam int H_P     = 1;
  localparam int H_LOCK  = 0;
  // default configuration (floating pins)
  localparam logic [9:0] DEF_M  = 10'h1F4;
  localparam logic [2:0] DEF_NA = 3'h2;
  localparam logic       DEF_NB = 1'h0;
  localparam logic       DEF_P  = 1'h0;
  // lock qualification length, cycles
  localparam int LOCK_QUAL_DEFAULT = 1024;
  // synchronizer bank layout
  localparam int NSYNC   = 24;
  localparam int SY_SCL  = 0;
  localparam int SY_SDA  = 1;
  localparam int SY_MR   = 2;
  localparam int SY_PSEL = 3;
  localparam int SY_LOCK = 4;
  localparam int SY_STOP = 5;
  localparam int SY_ADR  = 7;
  localparam int SY_M    = 9;
  localparam int SY_NA   = 19;
  localparam int SY_NB   = 22;
  localparam int SY_P    = 23;
  localparam logic [NSYNC-1:0] SYNC_RESET = 24'h000003;
  localparam logic [2:0] POST_CODE_MAX = 3'h5;
  typedef enum logic [3:0] {
    SCFG_IDLE, SCFG_ADDR, SCFG_ADDR_ACK, SCFG_ACK_HOLD, SCFG_TX, SCFG_TX_END,
    SCFG_MACK, SCFG_RX, SCFG_RX_END, SCFG_RX_ACK
  } scfg_state_type;
endpackage
`default_nettype wire

//--- hw/scfg_clk_if.sv
// interface: divider settings and stop controls toward the output gate
`default_nettype none
interface scfg_clk_if;
  logic [2:0] na;
  logic       nb;
  logic       run;
  logic [1:0] stop_n;
  logic [1:0] clk_out;
  modport ctrl (output na, nb, run, stop_n, input clk_out);
  modport gate (input na, nb, run, stop_n, output clk_out);
endinterface
`default_nettype wire

//--- hw/scfg_outgate.sv
// module: output divider with synchronous per-output clock stop
`default_nettype none
module scfg_outgate
  import scfg_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  nrst,
  scfg_clk_if.gate   cif
);
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic [1:0] en;
  logic [1:0] next_en;
  logic [1:0] outq;
  logic [1:0] next_outq;
  logic [1:0] raw;
  logic [2:0] k;

  always_comb begin
    k = (cif.na > POST_CODE_MAX) ? POST_CODE_MAX : cif.na;
    raw[0] = cnt[k];
    // half rate: xor keeps its rising edge on a primary rising edge
    raw[1] = cif.nb ? (cnt[k + 3'h1] ^ cnt[k]) : cnt[k];
    next_cnt = cif.run ? 7'(cnt + 7'h01) : 7'h00;
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_out
      always_comb begin
        // enable follows stop only while the raw clock is low; master reset clears it at once
        next_en[g] = raw[g] ? en[g] : cif.stop_n[g];
        next_outq[g] = raw[g] & next_en[g];
        if (!cif.run) begin
          next_en[g] = 1'b0;
          next_outq[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 7'h00;
      en <= 2'h0;
      outq <= 2'h0;
    end else begin
      cnt <= next_cnt;
      en <= next_en;
      outq <= next_outq;
    end
  end

  assign cif.clk_out = outq;
endmodule
`default_nettype wire

//--- testbench/scfg_top_assertions.sv
// checker: port timing relations of the configuration block
`default_nettype none
module scfg_top_assertions
  import scfg_pkg::*;
#(
  parameter int LOCK_QUAL_CYCLES = LOCK_QUAL_DEFAULT
) (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       master_reset_n,
  input wire logic       parallel_select_n,
  input wire logic [9:0] feedback_pins,
  input wire logic       pll_freq_lock,
  input wire logic [1:0] output_stop_n,
  input wire logic       lock_out,
  input wire logic [9:0] feedback_divider,
  input wire logic [2:0] primary_post_divider,
  input wire logic       primary_clock_out,
  input wire logic       secondary_clock_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // raw lock high time and both-stopped time, saturating
  logic [15:0] hi_cnt, next_hi_cnt, stop_cnt, next_stop_cnt;
  always_comb begin
    next_hi_cnt = !pll_freq_lock ? 16'h0000 : hi_cnt + {15'h0000, hi_cnt != 16'hFFFF};
    next_stop_cnt = (output_stop_n != 2'h0) ? 16'h0000 : stop_cnt + {15'h0000, stop_cnt != 16'hFFFF};
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt <= 16'h0000;
      stop_cnt <= 16'h0000;
    end else begin
      hi_cnt <= next_hi_cnt;
      stop_cnt <= next_stop_cnt;
    end
  end
  property p_lock_drop;
    $fell(pll_freq_lock) |-> ##[1:8] !lock_out;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock kept after loss");
  property p_lock_qual;
    $rose(lock_out) |-> hi_cnt >= 16'(LOCK_QUAL_CYCLES);
  endproperty
  a_lock_qual: assert property (p_lock_qual) else $error("lock reported early");
  property p_relock;
    hi_cnt == 16'(LOCK_QUAL_CYCLES + 12) |-> lock_out;
  endproperty
  a_relock: assert property (p_relock) else $error("lock not reported");
  property p_stop_low;
    stop_cnt >= 16'h0020 |-> !primary_clock_out && !secondary_clock_out;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("stopped output not low");
  property p_no_runt;
    master_reset_n [*8] ##0 ($rose(primary_clock_out) && primary_post_divider == 3'h2)
      |-> primary_clock_out [*4] ##1 !primary_clock_out;
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("primary pulse length wrong");
  property p_coincide;
    (master_reset_n && output_stop_n == 2'h3) [*8] ##0 $rose(secondary_clock_out) |-> $rose(primary_clock_out);
  endproperty
  a_coincide: assert property (p_coincide) else $error("secondary edge not on primary edge");
  property p_mr_low;
    !master_reset_n [*6] |-> !primary_clock_out && !secondary_clock_out;
  endproperty
  a_mr_low: assert property (p_mr_low) else $error("output high in master reset");
  property p_par_follow;
    (!parallel_select_n && master_reset_n && $stable(feedback_pins)) [*8] |-> feedback_divider == feedback_pins;
  endproperty
  a_par_follow: assert property (p_par_follow) else $error("divider not following pins");
  property p_capture;
    $rose(master_reset_n) |-> ##8 feedback_divider == $past(feedback_pins, 8);
  endproperty
  a_capture: assert property (p_capture) else $error("pins not captured");
endmodule
bind scfg_top scfg_top_assertions #(.LOCK_QUAL_CYCLES(LOCK_QUAL_CYCLES)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .master_reset_n(master_reset_n), .parallel_select_n(parallel_select_n),
  .feedback_pins(feedback_pins), .pll_freq_lock(pll_freq_lock), .output_stop_n(output_stop_n),
  .lock_out(lock_out), .feedback_divider(feedback_divider), .primary_post_divider(primary_post_divider),
  .primary_clock_out(primary_clock_out), .secondary_clock_out(secondary_clock_out)
);
`default_nettype wire

//--- testbench/scfg_i2c_master.sv
// partner: serial bus controller with a pull-up on the data line
`default_nettype none
module scfg_i2c_master (
  output logic      scl,
  output wire logic sda,
  input wire logic  sda_oe,
  input wire logic  sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam real Q = 31.25;
  logic pull_low;
  // released line floats high through the pull-up
  assign sda = (pull_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    pull_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start();
    pull_low = 1'b0;
    scl = 1'b1;
    #Q pull_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    pull_low = 1'b1;
    #Q scl = 1'b1;
    #Q pull_low = 1'b0;
    #Q;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule
`default_nettype wire

//--- testbench/scfg_top_tb.sv
// testbench: serial access, startup capture, lock and output control
`default_nettype none
module scfg_top_tb
  import scfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LQ = 16;
  logic        ref_clk = 1'b0;
  logic        nrst, master_reset_n, parallel_select_n, pll_freq_lock, nb_pin, p_pin;
  logic        sda_out, sda_oe, lock_out, pre_divider_sel, secondary_post_divider, primary_clock_out, secondary_clock_out;
  logic [1:0]  adr, output_stop_n;
  logic [2:0]  na_pins, primary_post_divider;
  logic [9:0]  feedback_pins, feedback_divider;
  logic [15:0] exp_q[$], got_val;
  wire logic   scl, sda;
  int          errors = 0, checked = 0;
  event        got;
  always #4 ref_clk = ~ref_clk;
  scfg_top #(.LOCK_QUAL_CYCLES(LQ)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_hi(adr[1]), .address_select_lo(adr[0]), .master_reset_n(master_reset_n),
    .parallel_select_n(parallel_select_n), .feedback_pins(feedback_pins), .primary_post_divider_pins(na_pins),
    .secondary_post_divider_pin(nb_pin), .pre_divider_pin(p_pin), .pll_freq_lock(pll_freq_lock),
    .output_stop_n(output_stop_n), .lock_out(lock_out), .feedback_divider(feedback_divider),
    .pre_divider_sel(pre_divider_sel), .primary_post_divider(primary_post_divider),
    .secondary_post_divider(secondary_post_divider), .primary_clock_out(primary_clock_out),
    .secondary_clock_out(secondary_clock_out)
  );
  scfg_i2c_master u_bus (.scl(scl), .sda(sda), .sda_oe(sda_oe), .sda_out(sda_out));
  // ----------------------------------------
  // scoreboard and drivers
  // ----------------------------------------
  always @(got) begin : watch
    logic [15:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 16'hDEAD;
    checked++;
    if (got_val !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got_val, e);
    end
  end
  task automatic give_verdict();
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic seen(input logic [15:0] exp, input logic [15:0] v);
    exp_q.push_back(exp);
    got_val = v;
    -> got;
    #1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, s, v);
        give_verdict();
      end
    end
  endtask
  function automatic logic [15:0] divs();
    return {1'b0, feedback_divider, primary_post_divider, secondary_post_divider, pre_divider_sel};
  endfunction
  task automatic rd(input logic [7:0] lo, input logic [7:0] hi, input logic [1:0] a_sel);
    logic [7:0] r;
    logic       a;
    u_bus.start();
    u_bus.xfer({ADDR_FIXED, a_sel, 1'b1}, 1'b1, r, a);
    seen({15'h0000, a_sel != adr}, {15'h0000, a});
    if (a_sel == adr) begin
      u_bus.xfer(8'hFF, 1'b0, r, a);
      seen({8'h00, lo}, {8'h00, r});
      u_bus.xfer(8'hFF, 1'b1, r, a);
      seen({8'h00, hi}, {8'h00, r});
    end
    u_bus.stop();
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] r;
    logic       a;
    u_bus.start();
    u_bus.xfer({ADDR_FIXED, adr, 1'b0}, 1'b1, r, a);
    u_bus.xfer(ptr, 1'b1, r, a);
    u_bus.xfer(d, 1'b1, r, a);
    u_bus.stop();
    cyc(4);
  endtask
  initial begin
    logic [9:0] m;
    logic [7:0] hb;
    void'($urandom(32'hECEBF07C));
    adr = 2'($urandom());
    nrst = 1'b0;
    master_reset_n = 1'b0;
    parallel_select_n = 1'b0;
    pll_freq_lock = 1'b0;
    output_stop_n = 2'h0;
    feedback_pins = DEF_M;
    na_pins = DEF_NA;
    nb_pin = DEF_NB;
    p_pin = DEF_P;
    cyc(4);
    nrst = 1'b1;
    cyc(4);
    master_reset_n = 1'b1;
    cyc(12);
    seen({1'b0, DEF_M, DEF_NA, DEF_NB, DEF_P}, divs());
    parallel_select_n = 1'b1;
    rd(DEF_M[7:0], {DEF_M[9:8], DEF_NA, DEF_NB, DEF_P, 1'b0}, adr);
    rd(8'h00, 8'h00, ~adr);
    pll_freq_lock = 1'b1;
    wait_for(lock_out, 1'b1, LQ + 40);
    output_stop_n = 2'h3;
    m = 10'(170 + $urandom_range(170));
    hb = {m[9:8], DEF_NA, 3'b110};
    wr(REG_L_OFFSET, m[7:0]);
    wr(REG_H_OFFSET, hb);
    seen({1'b0, DEF_M, DEF_NA, DEF_NB, DEF_P}, divs());
    rd(m[7:0], hb | 8'h01, adr);
    wr(REG_CMD_OFFSET, {4'hB, CMD_APPLY});
    seen({1'b0, m, DEF_NA, 2'b11}, divs());
    wr(REG_CMD_OFFSET, {4'h0, CMD_STEP_UP});
    wr(REG_CMD_OFFSET, {4'h5, CMD_STEP_DOWN});
    wr(REG_CMD_OFFSET, {4'h0, CMD_STEP_DOWN});
    seen({1'b0, m - 10'h001, DEF_NA, 2'b11}, divs());
    rd(m[7:0], hb | 8'h01, adr);
    wr(REG_CMD_OFFSET, {4'hA, CMD_READBACK});
    m = m - 10'h001;
    rd(m[7:0], {m[9:8], DEF_NA, 3'b111}, adr);
    pll_freq_lock = 1'b0;
    wait_for(lock_out, 1'b0, 10);
    pll_freq_lock = 1'b1;
    wait_for(lock_out, 1'b1, LQ + 40);
    output_stop_n = 2'h0;
    cyc(60);
    output_stop_n = 2'h2;
    cyc(40);
    output_stop_n = 2'h3;
    cyc(40);
    parallel_select_n = 1'b0;
    for (int i = 0; i < 2; i++) begin
      m = 10'(170 + $urandom_range(170));
      feedback_pins = m;
      p_pin = 1'b1;
      cyc(12);
      seen({1'b0, m, DEF_NA, 2'b01}, divs());
      wr(REG_L_OFFSET, ~m[7:0]);
      rd(m[7:0], {m[9:8], DEF_NA, 3'b011}, adr);
    end
    wait_for(primary_clock_out, 1'b1, 80);
    wait_for(primary_clock_out, 1'b0, 80);
    master_reset_n = 1'b0;
    parallel_select_n = 1'b1;
    m = 10'(170 + $urandom_range(170));
    feedback_pins = m;
    cyc(10);
    master_reset_n = 1'b1;
    cyc(12);
    seen({1'b0, m, DEF_NA, 2'b01}, divs());
    cyc(40);
    give_verdict();
  end
endmodule
`default_nettype wire
